// File: rtl/hcc_pkg.sv
// Package for the hub charging/power configuration register.
// Assumes a single core clock with synchronous active-high reset.
package hcc_pkg;
   // =========================================================================
   // Register map
   localparam logic [7:0] HCC_CFG_OFFSET   = 8'h0A;  // Configuration register address
   // =========================================================================
   // Field positions
   localparam int         HCC_BIT_RSVD_HI  = 7;      // Reserved, reads zero
   localparam int         HCC_BIT_UNLOCK   = 6;      // Charging feature unlock
   localparam int         HCC_BIT_POLARITY = 5;      // Power enable polarity
   localparam int         HCC_BIT_HICUR    = 4;      // High-current divider select
   localparam int         HCC_BIT_SPARE_HI = 3;      // Spare storage, upper bit
   localparam int         HCC_BIT_SPARE_LO = 2;      // Spare storage, lower bit
   localparam int         HCC_BIT_AUTO_DIS = 1;      // Automatic mode disable
   localparam int         HCC_BIT_RSVD_LO  = 0;      // Reserved, reads zero
   // =========================================================================
   // Reset values
   localparam logic       HCC_RST_UNLOCK   = 1'b0;   // Unlock clear after reset
   localparam logic [1:0] HCC_RST_SPARE    = 2'h0;   // Spare bits clear after reset
   localparam logic       HCC_RST_STRAP    = 1'b0;   // Strap-fed bits before capture
   localparam logic       HCC_RST_HICUR    = 1'b0;   // Divider select before first OTP copy
   localparam int         HCC_NUM_PORTS    = 4;      // Downstream ports
   // =========================================================================
   // Strap capture sequencer counts
   localparam logic [1:0] HCC_CAPTURE_AT   = 2'h2;   // Fill count at which straps are taken
   localparam logic [1:0] HCC_FILL_LAST    = 2'h3;   // Fill counter stops here
   // =========================================================================
   // Charging modes per port
   typedef enum logic [3:0]
   {
      HCC_MODE_OFF         = 4'h1,  // Charging disabled on port
      HCC_MODE_CONNECTED   = 4'h2,  // Upstream connected charging mode
      HCC_MODE_DEDICATED   = 4'h4,  // Fixed dedicated charging only
      HCC_MODE_AUTO        = 4'h8   // Automatic mode switching
   } hcc_mode_t;
   // Capture sequencer states
   typedef enum logic [2:0]
   {
      HCC_ST_RESET   = 3'h1,  // Held in reset
      HCC_ST_CAPTURE = 3'h2,  // Capture straps once the fill count reaches HCC_CAPTURE_AT
      HCC_ST_RUN     = 3'h4   // Normal operation
   } hcc_state_t;
endpackage

// File: rtl/hcc_sync.sv
// Two-flop synchroniser for one asynchronous pin level.
// Assumes the destination clock is the hub core clock.
`timescale 1ns/1ns
`default_nettype none
module hcc_sync
(
   input  wire logic clock,    // Core clock
   input  wire logic rst,      // Synchronous reset, active high
   input  wire logic async_in, // Pin level
   output logic      sync_out  // Synchronised level
);
   import hcc_pkg::*;
   logic meta_reg;

   // =========================================================================
   // Synchroniser; first stage only feeds the second
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         meta_reg <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule // hcc_sync
`default_nettype wire

// File: rtl/hcc_config.sv
// Hub charging and power-switch configuration register.
// Assumes write sources (EEPROM loader, SMBus slave) present one-cycle
// strobes on the core clock, and OTP and strap pins are static levels.
`timescale 1ns/1ns
`default_nettype none
module hcc_config
(
   input  wire logic                              clock,          // Core clock, 50 MHz
   input  wire logic                              rst,            // Sync reset, active high
   input  wire logic                              power_polarity_strap_pin,      // Strap
   input  wire logic                              auto_charge_suspend_strap_pin, // Strap
   input  wire logic                              otp_high_current_select, // OTP bit
   input  wire logic                              i2c_mode,       // EEPROM config mode
   input  wire logic                              smbus_mode,     // SMBus config mode
   input  wire logic                              eeprom_wr,      // EEPROM load strobe
   input  wire logic                              smbus_wr,       // SMBus write strobe
   input  wire logic [7:0]                        wr_addr,        // Write address
   input  wire logic [7:0]                        wr_data,        // Write data
   input  wire logic [7:0]                        rd_addr,        // Read address
   output logic      [7:0]                        rd_data,        // Read data, registered
   input  wire logic                              upstream_connected,    // Upstream link up
   input  wire logic [hcc_pkg::HCC_NUM_PORTS-1:0] port_power_on,  // Power request per port
   input  wire logic [hcc_pkg::HCC_NUM_PORTS-1:0] port_charge_en, // Charging per port
   output logic      [hcc_pkg::HCC_NUM_PORTS-1:0] port_power_enable_out, // Power pins
   output logic      [hcc_pkg::HCC_NUM_PORTS*4-1:0] port_charge_mode, // One-hot per port
   output logic                                   divider_charge_level_two,   // Level 2
   output logic                                   divider_charge_level_three  // Level 3
);
   import hcc_pkg::*;

   hcc_state_t state_reg;
   hcc_state_t state_next;
   logic       pol_sync;
   logic       auto_sync;
   logic       charge_feature_unlock_reg;
   logic       power_enable_polarity_reg;
   logic       high_current_divider_select_reg;
   logic [1:0] spare_reg;
   logic       auto_charge_disable_reg;
   logic       wr_hit;
   logic       wr_ok;
   logic [7:0] cfg_view;

   // =========================================================================
   // Strap synchronisers
   hcc_sync u_pol_sync
   (
      .clock    (clock),
      .rst      (rst),
      .async_in (power_polarity_strap_pin),
      .sync_out (pol_sync)
   );
   hcc_sync u_auto_sync
   (
      .clock    (clock),
      .rst      (rst),
      .async_in (auto_charge_suspend_strap_pin),
      .sync_out (auto_sync)
   );

   // =========================================================================
   // Capture sequencer: wait for the sync chain to fill before sampling
   logic [1:0] fill_reg;
   always_ff @(posedge clock)
   begin
      if (rst)
         fill_reg <= 2'h0;
      else if (fill_reg != HCC_FILL_LAST)
         fill_reg <= fill_reg + 2'h1;
   end

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         HCC_ST_RESET:   state_next = HCC_ST_CAPTURE;
         HCC_ST_CAPTURE: if (fill_reg == HCC_CAPTURE_AT) state_next = HCC_ST_RUN;
         HCC_ST_RUN:     state_next = HCC_ST_RUN;
         default:        state_next = HCC_ST_RESET;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         state_reg <= HCC_ST_RESET;
      else
         state_reg <= state_next;
   end

   // =========================================================================
   // Write qualification; writes before strap capture finish are dropped
   // so the strap value is not overtaken by an early load
   assign wr_hit = (eeprom_wr && i2c_mode) || (smbus_wr && smbus_mode);
   assign wr_ok  = wr_hit && (wr_addr == HCC_CFG_OFFSET) && (state_reg == HCC_ST_RUN);

   // =========================================================================
   // Unlock bit
   always_ff @(posedge clock)
   begin
      if (rst)
         charge_feature_unlock_reg <= HCC_RST_UNLOCK;
      else if (wr_ok)
         charge_feature_unlock_reg <= wr_data[HCC_BIT_UNLOCK];
   end

   // =========================================================================
   // Divider select: unlock in the same write data opens the field at once
   always_ff @(posedge clock)
   begin
      if (rst)
         high_current_divider_select_reg <= HCC_RST_HICUR;
      else if (wr_ok && wr_data[HCC_BIT_UNLOCK])
         high_current_divider_select_reg <= wr_data[HCC_BIT_HICUR];
      else if (!charge_feature_unlock_reg)
         high_current_divider_select_reg <= otp_high_current_select;
   end

   // =========================================================================
   // Polarity and auto-disable: strap capture, then EEPROM or SMBus writes
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         power_enable_polarity_reg <= HCC_RST_STRAP;
         auto_charge_disable_reg   <= HCC_RST_STRAP;
      end
      else if (state_reg == HCC_ST_CAPTURE && fill_reg == HCC_CAPTURE_AT)
      begin
         power_enable_polarity_reg <= pol_sync;
         auto_charge_disable_reg   <= auto_sync;
      end
      else if (wr_ok)
      begin
         power_enable_polarity_reg <= wr_data[HCC_BIT_POLARITY];
         auto_charge_disable_reg   <= wr_data[HCC_BIT_AUTO_DIS];
      end
   end

   // =========================================================================
   // Spare storage bits
   always_ff @(posedge clock)
   begin
      if (rst)
         spare_reg <= HCC_RST_SPARE;
      else if (wr_ok)
         spare_reg <= wr_data[HCC_BIT_SPARE_HI:HCC_BIT_SPARE_LO];
   end

   // =========================================================================
   // Read view; reserved bits have no storage so writes vanish
   always_comb
   begin
      cfg_view                                    = 8'h00;
      cfg_view[HCC_BIT_RSVD_HI]                   = 1'b0;
      cfg_view[HCC_BIT_UNLOCK]                    = charge_feature_unlock_reg;
      cfg_view[HCC_BIT_POLARITY]                  = power_enable_polarity_reg;
      cfg_view[HCC_BIT_HICUR]                     = high_current_divider_select_reg;
      cfg_view[HCC_BIT_SPARE_HI:HCC_BIT_SPARE_LO] = spare_reg;
      cfg_view[HCC_BIT_AUTO_DIS]                  = auto_charge_disable_reg;
      cfg_view[HCC_BIT_RSVD_LO]                   = 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         rd_data <= 8'h00;
      else if (rd_addr == HCC_CFG_OFFSET)
         rd_data <= cfg_view;
      else
         rd_data <= 8'h00;
   end

   // =========================================================================
   // Power enable pins: polarity applied per port
   always_ff @(posedge clock)
   begin
      if (rst)
         port_power_enable_out <= '0;
      else if (power_enable_polarity_reg)
         port_power_enable_out <= port_power_on;
      else
         port_power_enable_out <= ~port_power_on;
   end

   // =========================================================================
   // Per-port charging mode selection
   always_ff @(posedge clock)
   begin
      if (rst)
         port_charge_mode <= {HCC_NUM_PORTS{HCC_MODE_OFF}};
      else
         for (int i = 0; i < HCC_NUM_PORTS; i++)
         begin
            if (!port_charge_en[i])
               port_charge_mode[i*4 +: 4] <= HCC_MODE_OFF;
            else if (upstream_connected)
               port_charge_mode[i*4 +: 4] <= HCC_MODE_CONNECTED;
            else if (auto_charge_disable_reg)
               port_charge_mode[i*4 +: 4] <= HCC_MODE_DEDICATED;
            else
               port_charge_mode[i*4 +: 4] <= HCC_MODE_AUTO;
         end
   end

   // High-current divider level used by automatic mode
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         divider_charge_level_two   <= 1'b0;
         divider_charge_level_three <= 1'b0;
      end
      else
      begin
         divider_charge_level_two   <= !auto_charge_disable_reg && !high_current_divider_select_reg;
         divider_charge_level_three <= !auto_charge_disable_reg && high_current_divider_select_reg;
      end
   end

   // =========================================================================
   // Assertions
   // Look-back checks skip the first edge after reset, where registered
   // outputs still carry reset values rather than a function of the inputs
   a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
      (rd_data[HCC_BIT_RSVD_HI] == 1'b0) && (rd_data[HCC_BIT_RSVD_LO] == 1'b0))
      else $error("reserved bit reads nonzero");
   a_locked_otp: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) && $past(!charge_feature_unlock_reg)
      && !$past(wr_ok && wr_data[HCC_BIT_UNLOCK])
      |-> high_current_divider_select_reg == $past(otp_high_current_select))
      else $error("locked divider select not from OTP");
   a_unlock_same_write: assert property (@(posedge clock) disable iff (rst)
      wr_ok && wr_data[HCC_BIT_UNLOCK] |=> charge_feature_unlock_reg
      && high_current_divider_select_reg == $past(wr_data[HCC_BIT_HICUR]))
      else $error("combined unlock write not applied");
   a_polarity_pin: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) |-> port_power_enable_out ==
      ($past(power_enable_polarity_reg) ? $past(port_power_on) : ~$past(port_power_on)))
      else $error("power enable polarity wrong");
   a_strap_capture: assert property (@(posedge clock) disable iff (rst)
      state_reg == HCC_ST_CAPTURE && fill_reg == HCC_CAPTURE_AT |=>
      power_enable_polarity_reg == $past(pol_sync)
      && auto_charge_disable_reg == $past(auto_sync))
      else $error("strap not captured");
   a_early_write_drop: assert property (@(posedge clock) disable iff (rst)
      wr_hit && state_reg != HCC_ST_RUN |=>
      $stable(charge_feature_unlock_reg) && $stable(spare_reg))
      else $error("write before strap capture applied");
   a_polarity_write: assert property (@(posedge clock) disable iff (rst)
      wr_ok |=> power_enable_polarity_reg == $past(wr_data[HCC_BIT_POLARITY])
      && auto_charge_disable_reg == $past(wr_data[HCC_BIT_AUTO_DIS]))
      else $error("polarity write not applied");
   a_spare_store: assert property (@(posedge clock) disable iff (rst)
      wr_ok |=> spare_reg == $past(wr_data[HCC_BIT_SPARE_HI:HCC_BIT_SPARE_LO]))
      else $error("spare bits not stored");
   a_connected_mode: assert property (@(posedge clock) disable iff (rst)
      upstream_connected && port_charge_en[0] |=>
      port_charge_mode[3:0] == HCC_MODE_CONNECTED)
      else $error("connected mode not used");
   a_charge_off: assert property (@(posedge clock) disable iff (rst)
      !port_charge_en[HCC_NUM_PORTS-1] |=>
      port_charge_mode[HCC_NUM_PORTS*4-1 -: 4] == HCC_MODE_OFF)
      else $error("disabled port not off");
   a_level_select: assert property (@(posedge clock) disable iff (rst)
      !auto_charge_disable_reg && high_current_divider_select_reg |=>
      divider_charge_level_three && !divider_charge_level_two)
      else $error("divider level three wrong");
   a_level_two: assert property (@(posedge clock) disable iff (rst)
      !auto_charge_disable_reg && !high_current_divider_select_reg |=>
      divider_charge_level_two && !divider_charge_level_three)
      else $error("divider level two wrong");
   a_auto_disable: assert property (@(posedge clock) disable iff (rst)
      auto_charge_disable_reg && !upstream_connected && port_charge_en[0] |=>
      port_charge_mode[3:0] == HCC_MODE_DEDICATED)
      else $error("auto disable ignored");

   // Covers: both write sources, unlock and relock, and a write refused
   // while the straps are still being captured
   c_smbus_write: cover property (@(posedge clock) smbus_wr && wr_ok);
   c_eeprom_write: cover property (@(posedge clock) eeprom_wr && wr_ok);
   c_unlock_write: cover property (@(posedge clock) wr_ok && wr_data[HCC_BIT_UNLOCK]);
   c_relock_write: cover property (@(posedge clock)
      wr_ok && charge_feature_unlock_reg && !wr_data[HCC_BIT_UNLOCK]);
   c_early_write: cover property (@(posedge clock) wr_hit && state_reg != HCC_ST_RUN);
endmodule // hcc_config
`default_nettype wire

// File: bench/hcc_host_model.sv
// Far-side write source: stands in for the SMBus host and the serial EEPROM loader.
// Assumes the bench calls write() after the strap capture, apart from one call made during capture to check refusal.
`timescale 1ns/1ns
`default_nettype none
module hcc_host_model
(
   input  wire logic       clock,     // Core clock
   output logic            eeprom_wr, // EEPROM load strobe
   output logic            smbus_wr,  // SMBus write strobe
   output logic      [7:0] wr_addr,   // Write address
   output logic      [7:0] wr_data    // Write data
);
   // =========================================================================
   // Idle levels at time zero
   initial
   begin
      eeprom_wr = 1'b0;
      smbus_wr  = 1'b0;
      wr_addr   = 8'h00;
      wr_data   = 8'h00;
   end
   // One-cycle strobe; released lines flip so stale data can never match
   task automatic write(input logic eep, input logic [7:0] addr, input logic [7:0] data);
      @(posedge clock);
      #1;
      eeprom_wr = eep;
      smbus_wr  = ~eep;
      wr_addr   = addr;
      wr_data   = data;
      @(posedge clock);
      #1;
      eeprom_wr = 1'b0;
      smbus_wr  = 1'b0;
      wr_addr   = ~addr;
      wr_data   = ~data;
   endtask
endmodule // hcc_host_model
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the charging configuration register.
// Assumes the far side is the host model and every input moves 1 ns after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import hcc_pkg::*;
   logic        clock;
   logic        rst;
   logic        pol_strap;
   logic        auto_strap;
   logic        otp_sel;
   logic        i2c_mode;
   logic        smbus_mode;
   wire logic   eeprom_wr;
   wire logic   smbus_wr;
   wire logic [7:0] wr_addr;
   wire logic [7:0] wr_data;
   logic [7:0]  rd_addr;
   logic [7:0]  rd_data;
   logic        upstream;
   logic [3:0]  power_on;
   logic [3:0]  charge_en;
   logic [3:0]  power_out;
   logic [15:0] charge_mode;
   logic        level_two;
   logic        level_three;
   int          error_cnt;
   int          n_tests;
   // =========================================================================
   // Instances
   hcc_host_model i_hcc_host_model (.clock(clock), .eeprom_wr(eeprom_wr), .smbus_wr(smbus_wr),
      .wr_addr(wr_addr), .wr_data(wr_data));
   hcc_config i_hcc_config (.clock(clock), .rst(rst), .power_polarity_strap_pin(pol_strap),
      .auto_charge_suspend_strap_pin(auto_strap), .otp_high_current_select(otp_sel),
      .i2c_mode(i2c_mode), .smbus_mode(smbus_mode), .eeprom_wr(eeprom_wr),
      .smbus_wr(smbus_wr), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
      .rd_data(rd_data), .upstream_connected(upstream), .port_power_on(power_on),
      .port_charge_en(charge_en), .port_power_enable_out(power_out),
      .port_charge_mode(charge_mode), .divider_charge_level_two(level_two),
      .divider_charge_level_three(level_three));
   // =========================================================================
   // Clock, 20 ns period
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // =========================================================================
   // Checking tasks
   task automatic print_verdict();
      if (error_cnt == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Registered read: data lands on the same edge that samples the address
   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge clock);
      #1;
      rd_addr = addr;
      @(posedge clock);
      #1;
      chk("rd_data", {8'h00, exp}, {8'h00, rd_data});
   endtask
   // Outputs are registered, so let two edges pass before looking
   task automatic outs(input logic [3:0] pwr, input logic [15:0] mode, input logic [1:0] lvl);
      repeat (2) @(posedge clock);
      #1;
      chk("power_out", {12'h000, pwr}, {12'h000, power_out});
      chk("charge_mode", mode, charge_mode);
      chk("levels", {14'h0000, lvl}, {14'h0000, level_two, level_three});
   endtask
   // =========================================================================
   // Watchdog, far beyond the roughly 70 cycles the tests need
   initial
   begin
      #(3000 * 20);
      error_cnt++;
      print_verdict();
   end
   // =========================================================================
   // Main sequence
   initial
   begin
      error_cnt = 0;
      n_tests = 0;
      rst = 1'b1;
      pol_strap = 1'b1;
      auto_strap = 1'b1;
      otp_sel = 1'b0;
      i2c_mode = 1'b0;
      smbus_mode = 1'b1;
      rd_addr = 8'h00;
      upstream = 1'b0;
      power_on = 4'h5;
      charge_en = 4'h3;
      repeat (8) @(posedge clock);
      #1;
      rst = 1'b0;
      repeat (6) @(posedge clock);
      #1;
      rd_chk(HCC_CFG_OFFSET, 8'h22);
      outs(4'h5, 16'h1144, 2'b00);
      // Unlock and divider select in one write; reserved bits must stay zero
      i_hcc_host_model.write(1'b0, HCC_CFG_OFFSET, 8'hDD);
      rd_chk(HCC_CFG_OFFSET, 8'h5C);
      outs(4'hA, 16'h1188, 2'b01);
      upstream = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk("charge_mode", 16'h1122, charge_mode);
      upstream = 1'b0;
      // Relock, then a locked write to the divider select must be dropped
      i_hcc_host_model.write(1'b0, HCC_CFG_OFFSET, 8'h00);
      rd_chk(HCC_CFG_OFFSET, 8'h00);
      i_hcc_host_model.write(1'b0, HCC_CFG_OFFSET, 8'h10);
      rd_chk(HCC_CFG_OFFSET, 8'h00);
      otp_sel = 1'b1;
      rd_chk(HCC_CFG_OFFSET, 8'h10);
      outs(4'hA, 16'h1188, 2'b01);
      otp_sel = 1'b0;
      outs(4'hA, 16'h1188, 2'b10);
      // EEPROM mode: loader sets polarity, host and stray addresses are ignored
      i2c_mode = 1'b1;
      smbus_mode = 1'b0;
      i_hcc_host_model.write(1'b1, HCC_CFG_OFFSET, 8'h22);
      rd_chk(HCC_CFG_OFFSET, 8'h22);
      outs(4'h5, 16'h1144, 2'b00);
      i_hcc_host_model.write(1'b0, HCC_CFG_OFFSET, 8'h00);
      rd_chk(HCC_CFG_OFFSET, 8'h22);
      i_hcc_host_model.write(1'b1, 8'h0B, 8'h00);
      rd_chk(HCC_CFG_OFFSET, 8'h22);
      rd_chk(8'h0B, 8'h00);
      // Second reset with both straps low; a write inside capture is refused
      pol_strap = 1'b0;
      auto_strap = 1'b0;
      rst = 1'b1;
      repeat (8) @(posedge clock);
      #1;
      rst = 1'b0;
      i_hcc_host_model.write(1'b1, HCC_CFG_OFFSET, 8'h7E);
      rd_chk(HCC_CFG_OFFSET, 8'h00);
      outs(4'hA, 16'h1188, 2'b10);
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
